// ---- verilog/ehwdg_consts.svh ----
`ifndef EHWDG_CONSTS_SVH
`define EHWDG_CONSTS_SVH

// ==========================================================
// timing figures
`define EHWDG_MCLK_HZ      50000000
`define EHWDG_REF_HZ       32768
`define EHWDG_BAUD         9600
`define EHWDG_PULSE_US     1000
`define EHWDG_BASE_MS      1000
`define EHWDG_STEP_MS      200
`define EHWDG_MS_PER_S     1000
`define EHWDG_US_PER_S     1000000

// ==========================================================
// selection codes
`define EHWDG_DEFAULT_SEL  3'h3
`define EHWDG_MAX_SEL      8'h05
`define EHWDG_SEL_W        3
`define EHWDG_TICK_W       17
`define EHWDG_BIT_LAST     3'h7

`endif

// ---- verilog/ehwdg_pkg.sv ----
package ehwdg_pkg;

  typedef enum logic [0:0]
  {
    EHWDG_RUN   = 1'b0,
    EHWDG_PULSE = 1'b1
  } ehwdg_state_t;

  typedef enum logic [1:0]
  {
    EHWDG_RX_IDLE  = 2'b00,
    EHWDG_RX_START = 2'b01,
    EHWDG_RX_DATA  = 2'b10,
    EHWDG_RX_STOP  = 2'b11
  } ehwdg_rx_state_t;

endpackage

// ---- verilog/ehwdg_uart_rx.sv ----
`timescale 1ns/1ns
`include "ehwdg_consts.svh"

module ehwdg_uart_rx
  import ehwdg_pkg::*;
#(
  parameter int BIT_CYCLES = `EHWDG_MCLK_HZ / `EHWDG_BAUD
)
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       rxd,
  output logic            byteValid,
  output logic [7:0]      byteData
);

  localparam int HALF_CYCLES = BIT_CYCLES / 2;

  ehwdg_rx_state_t state_q;
  logic [15:0]     bitTimer_q;
  logic [2:0]      bitIdx_q;
  logic [7:0]      shift_q;
  logic            timerDone;

  assign timerDone = (bitTimer_q == 16'(BIT_CYCLES - 1));

  // ==========================================================
  // frame receiver: 8 data bits, lsb first, no parity, one stop
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q    <= EHWDG_RX_IDLE;
      bitTimer_q <= 16'h0000;
      bitIdx_q   <= 3'h0;
      shift_q    <= 8'h00;
      byteValid  <= 1'b0;
      byteData   <= 8'h00;
    end
    else
    begin
      byteValid <= 1'b0;
      case (state_q)
        EHWDG_RX_IDLE:
        begin
          bitTimer_q <= 16'h0000;
          if (!rxd)
            state_q <= EHWDG_RX_START;
        end
        EHWDG_RX_START:
        begin
          // sample mid start bit; a short glitch falls back to idle
          if (bitTimer_q == 16'(HALF_CYCLES - 1))
          begin
            bitTimer_q <= 16'h0000;
            bitIdx_q   <= 3'h0;
            state_q    <= rxd ? EHWDG_RX_IDLE : EHWDG_RX_DATA;
          end
          else
            bitTimer_q <= bitTimer_q + 16'h0001;
        end
        EHWDG_RX_DATA:
        begin
          if (timerDone)
          begin
            bitTimer_q <= 16'h0000;
            shift_q    <= {rxd, shift_q[7:1]};
            bitIdx_q   <= bitIdx_q + 3'h1;
            if (bitIdx_q == `EHWDG_BIT_LAST)
              state_q <= EHWDG_RX_STOP;
          end
          else
            bitTimer_q <= bitTimer_q + 16'h0001;
        end
        EHWDG_RX_STOP:
        begin
          if (timerDone)
          begin
            // framing error drops the byte silently
            if (rxd)
            begin
              byteValid <= 1'b1;
              byteData  <= shift_q;
            end
            state_q <= EHWDG_RX_IDLE;
          end
          else
            bitTimer_q <= bitTimer_q + 16'h0001;
        end
        default:
          state_q <= EHWDG_RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_stop_frame: assert property
    (byteValid |-> $past(state_q) == EHWDG_RX_STOP && $past(rxd))
    else $error("byte accepted outside a good stop bit");
  chk_bit_timer: assert property (bitTimer_q < 16'(BIT_CYCLES))
    else $error("bit timer past one bit period");

endmodule

// ---- verilog/ehwdg_top.sv ----
`timescale 1ns/1ns
`include "ehwdg_consts.svh"

module ehwdg_top
  import ehwdg_pkg::*;
#(
  parameter int REF_HZ       = `EHWDG_REF_HZ,
  parameter int PULSE_TICKS  =
    (`EHWDG_PULSE_US * `EHWDG_REF_HZ + `EHWDG_US_PER_S - 1) / `EHWDG_US_PER_S,
  parameter int BIT_CYCLES   = `EHWDG_MCLK_HZ / `EHWDG_BAUD
)
(
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     refClk,
  input  wire logic                     keepaliveIn,
  input  wire logic                     uartRxd,
  output logic                          hostResetN,
  output logic [`EHWDG_SEL_W-1:0]       activeSel
);

  // ==========================================================
  // helpers
  function automatic logic [`EHWDG_TICK_W-1:0] toTicks(input logic [`EHWDG_SEL_W-1:0] sel);
    int ms;
    ms = `EHWDG_BASE_MS + `EHWDG_STEP_MS * int'(sel);
    // truncation keeps the timeout no longer than its nominal value
    return `EHWDG_TICK_W'((ms * REF_HZ) / `EHWDG_MS_PER_S);
  endfunction

  ehwdg_state_t                state_q;
  logic                        refPrev_q;
  logic                        kaPrev_q;
  logic [`EHWDG_SEL_W-1:0]     sel_q;
  logic [`EHWDG_TICK_W-1:0]    cnt_q;
  logic [`EHWDG_TICK_W-1:0]    periodTicks_q;
  logic [15:0]                 pulseCnt_q;
  logic [15:0]                 lowTicks_q;
  logic                        seenCmd_q;
  logic                        tick;
  logic                        kaFall;
  logic                        timeout;
  logic                        pulseEnd;
  logic                        rxValid;
  logic [7:0]                  rxData;

  // ==========================================================
  // command receiver
  ehwdg_uart_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) uRx (
    .mclk      (mclk),
    .rstn      (rstn),
    .rxd       (uartRxd),
    .byteValid (rxValid),
    .byteData  (rxData)
  );

  // ==========================================================
  // edge detection
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      // a reference already high at release is not a fresh tick
      refPrev_q <= 1'b1;
      kaPrev_q  <= 1'b1;
    end
    else
    begin
      refPrev_q <= refClk;
      kaPrev_q  <= keepaliveIn;
    end
  end

  // own reference, not the host clock, times the period, but it is sampled on mclk, so a dead mclk never trips
  assign tick     = refClk & ~refPrev_q;
  assign kaFall   = kaPrev_q & ~keepaliveIn;
  assign timeout  = (state_q == EHWDG_RUN) && tick && !kaFall &&
                    (cnt_q == periodTicks_q - `EHWDG_TICK_W'(1));
  assign pulseEnd = (state_q == EHWDG_PULSE) && tick &&
                    (pulseCnt_q == 16'(PULSE_TICKS - 1));

  // ==========================================================
  // timeout selection
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_q     <= `EHWDG_DEFAULT_SEL;
      seenCmd_q <= 1'b0;
    end
    else if (rxValid && rxData <= `EHWDG_MAX_SEL)
    begin
      sel_q     <= rxData[`EHWDG_SEL_W-1:0];
      seenCmd_q <= 1'b1;
    end
  end

  assign activeSel = sel_q;

  // ==========================================================
  // supervisor
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q       <= EHWDG_RUN;
      cnt_q         <= `EHWDG_TICK_W'(0);
      periodTicks_q <= toTicks(`EHWDG_DEFAULT_SEL);
      pulseCnt_q    <= 16'h0000;
      hostResetN    <= 1'b1;
    end
    else
    begin
      case (state_q)
        EHWDG_RUN:
        begin
          if (kaFall)
          begin
            cnt_q         <= `EHWDG_TICK_W'(0);
            periodTicks_q <= toTicks(sel_q);
          end
          else if (timeout)
          begin
            // no edge yet after start-up means pulses keep repeating
            state_q    <= EHWDG_PULSE;
            pulseCnt_q <= 16'h0000;
            hostResetN <= 1'b0;
          end
          else if (tick)
            cnt_q <= cnt_q + `EHWDG_TICK_W'(1);
        end
        EHWDG_PULSE:
        begin
          // keep-alive edges during the pulse are ignored
          if (pulseEnd)
          begin
            state_q       <= EHWDG_RUN;
            hostResetN    <= 1'b1;
            cnt_q         <= `EHWDG_TICK_W'(0);
            periodTicks_q <= toTicks(sel_q);
          end
          else if (tick)
            pulseCnt_q <= pulseCnt_q + 16'h0001;
        end
        default:
          state_q <= EHWDG_RUN;
      endcase
    end
  end

  // ==========================================================
  // pulse width monitor
  // counted apart from the supervisor, so a wrong pulse counter shows
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      lowTicks_q <= 16'h0000;
    else if (hostResetN)
      lowTicks_q <= 16'h0000;
    else if (tick)
      lowTicks_q <= lowTicks_q + 16'h0001;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_timeout_pulse: assert property (timeout |=> !hostResetN && state_q == EHWDG_PULSE)
    else $error("timeout did not start reset pulse");
  chk_keepalive_restart: assert property
    ((kaFall && state_q == EHWDG_RUN) |=> cnt_q == `EHWDG_TICK_W'(0) && hostResetN)
    else $error("keep-alive edge did not restart counter");
  chk_pulse_end_restart: assert property
    ($rose(hostResetN) |-> cnt_q == `EHWDG_TICK_W'(0) && periodTicks_q == toTicks($past(sel_q)))
    else $error("pulse end did not restart with selected period");
  chk_default_sel: assert property (!seenCmd_q |-> sel_q == `EHWDG_DEFAULT_SEL)
    else $error("default selection lost before any command");
  chk_bad_cmd: assert property ((rxValid && rxData > `EHWDG_MAX_SEL) |=> $stable(sel_q))
    else $error("invalid command changed timeout");
  chk_good_cmd: assert property
    ((rxValid && rxData <= `EHWDG_MAX_SEL) |=> sel_q == $past(rxData[`EHWDG_SEL_W-1:0]))
    else $error("valid command not applied");
  chk_pulse_len: assert property (pulseCnt_q < 16'(PULSE_TICKS))
    else $error("pulse longer than configured");
  chk_count_bound: assert property (state_q == EHWDG_RUN |-> cnt_q < periodTicks_q)
    else $error("counter beyond selected period");
  chk_period_range: assert property
    (periodTicks_q >= toTicks(3'h0) && periodTicks_q <= toTicks(3'h5))
    else $error("period outside one to two seconds");
  chk_pulse_ticks: assert property
    ($rose(hostResetN) |-> lowTicks_q == 16'(PULSE_TICKS))
    else $error("reset pulse width differs from configured ticks");
  chk_low_in_pulse: assert property (!hostResetN |-> state_q == EHWDG_PULSE)
    else $error("reset output low outside a pulse");
  chk_sel_range: assert property ({5'h00, activeSel} <= `EHWDG_MAX_SEL)
    else $error("active selection outside valid codes");
  chk_period_hold: assert property
    (!(kaFall && state_q == EHWDG_RUN) && !pulseEnd |=> $stable(periodTicks_q))
    else $error("period changed without a restart");

  cov_pulse: cover property ($fell(hostResetN));
  cov_pulse_done: cover property ($rose(hostResetN));
  cov_keepalive: cover property (kaFall && state_q == EHWDG_RUN && cnt_q != 0);
  cov_new_sel: cover property (rxValid && rxData <= `EHWDG_MAX_SEL && rxData[2:0] != sel_q);
  cov_bad_cmd: cover property (rxValid && rxData > `EHWDG_MAX_SEL);

endmodule

// ---- testbench/ehwdg_host_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// host side: keep-alive toggler and command sender
module ehwdg_host_model
  import ehwdg_pkg::*;
#(
  parameter int BIT_CYCLES = 16,
  parameter int KA_HALF    = 500
)
(
  input  wire logic mclk,
  input  wire logic hostResetN,
  input  wire logic kaRun,
  output logic      keepaliveIn,
  output logic      uartRxd
);
  int kaCnt;

  initial
  begin
    keepaliveIn = 1'b1;
    uartRxd     = 1'b1;
    kaCnt       = 0;
  end

  // a host held in reset cannot toggle, so it pauses
  always @(negedge mclk)
  begin
    if (kaRun && hostResetN)
    begin
      kaCnt <= kaCnt + 1;
      if (kaCnt == KA_HALF - 1)
      begin
        kaCnt       <= 0;
        keepaliveIn <= ~keepaliveIn;
      end
    end
  end

  // start, eight data bits lsb first, one stop, no parity
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      uartRxd = f[i];
      repeat (BIT_CYCLES) @(negedge mclk);
    end
  endtask
endmodule

// ---- testbench/ehwdg_test.sv ----
`timescale 1ns/1ns
module ehwdg_test
  import ehwdg_pkg::*;
;
  // ==========================================================
  // set-up
  // reference period unrelated to mclk, ticks shortened by REF_HZ
  localparam int REF_NS = 164;
  localparam int PULSE_T = 4;
  logic       mclk;
  logic       rstn;
  logic       refClk;
  logic       kaRun;
  logic       keepaliveIn;
  logic       uartRxd;
  logic       hostResetN;
  logic [2:0] activeSel;
  int         n_fail;
  int         checks_done;
  longint     ns;

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  // odd edge times never meet an mclk edge, so no sampling race
  initial
  begin
    refClk = 1'b0;
    #67;
    forever #82 refClk = ~refClk;
  end

  ehwdg_top #(.REF_HZ(100), .PULSE_TICKS(PULSE_T), .BIT_CYCLES(16)) dut_u
  (
    .mclk        (mclk),
    .rstn        (rstn),
    .refClk      (refClk),
    .keepaliveIn (keepaliveIn),
    .uartRxd     (uartRxd),
    .hostResetN  (hostResetN),
    .activeSel   (activeSel)
  );

  ehwdg_host_model host_u
  (
    .mclk        (mclk),
    .hostResetN  (hostResetN),
    .kaRun       (kaRun),
    .keepaliveIn (keepaliveIn),
    .uartRxd     (uartRxd)
  );

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic waitLvl(input logic lvl, input int bound, output longint t);
    longint t0;
    int     k;
    t0 = $time;
    k = 0;
    while (hostResetN !== lvl && k < bound)
    begin
      @(negedge mclk);
      k++;
    end
    t = $time - t0;
    if (k >= bound)
    begin
      n_fail++;
      complete_run();
    end
  endtask

  // one tick of quantisation plus a few cycles of sync delay allowed
  task automatic span(input string what, input longint t, input int ticks);
    logic ok;
    ok = (t >= ticks * REF_NS - 60) && (t <= (ticks + 1) * REF_NS + 60);
    check(what, ok ? ticks : 32'(t / REF_NS), ticks);
  endtask

  // ==========================================================
  // scenarios
  task automatic scenStartup;
    check("sel after reset", activeSel, 3'h3);
    waitLvl(1'b0, 4000, ns);
    span("first timeout", ns, 160);
    waitLvl(1'b1, 400, ns);
    span("pulse length", ns, PULSE_T);
    waitLvl(1'b0, 4000, ns);
    span("repeat period", ns, 160);
    waitLvl(1'b1, 400, ns);
  endtask

  task automatic scenFed;
    int lows;
    lows = 0;
    kaRun = 1'b1;
    repeat (8000)
    begin
      @(negedge mclk);
      if (hostResetN !== 1'b1)
        lows++;
    end
    kaRun = 1'b0;
    check("reset while fed", lows, 0);
  endtask

  task automatic scenPeriods;
    for (int s = 0; s < 6; s++)
    begin
      host_u.sendByte(8'(s));
      check("activeSel", activeSel, 32'(s));
      waitLvl(1'b0, 4000, ns);
      waitLvl(1'b1, 400, ns);
      waitLvl(1'b0, 4000, ns);
      span("period", ns, 100 + 20 * s);
    end
  endtask

  task automatic scenInvalid;
    host_u.sendByte(8'h06);
    host_u.sendByte(8'hFF);
    check("sel after bad", activeSel, 3'h5);
    waitLvl(1'b0, 4000, ns);
    waitLvl(1'b1, 400, ns);
    waitLvl(1'b0, 4000, ns);
    span("period after bad", ns, 200);
  endtask

  task automatic scenReset;
    rstn = 1'b0;
    @(negedge mclk);
    check("reset out in reset", hostResetN, 1'b1);
    check("sel in reset", activeSel, 3'h3);
    repeat (15) @(negedge mclk);
    rstn = 1'b1;
    waitLvl(1'b0, 4000, ns);
    waitLvl(1'b1, 400, ns);
    waitLvl(1'b0, 4000, ns);
    span("period after reset", ns, 160);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    kaRun = 1'b0;
    rstn = 1'b0;
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    scenStartup();
    scenFed();
    scenPeriods();
    scenInvalid();
    scenReset();
    complete_run();
  end
endmodule
